// >>> hw/tcc_pkg.sv
// Constants, types and register map of the 16-bit capture/compare timer.
// Assumes a 10 MHz system clock and a 32-bit APB register port.
`default_nettype none
package tcc_pkg;
    // Register indices; the byte address is four times the index
    localparam int unsigned ADDR_W = 18;
    localparam logic [15:0] IDX_COUNTER = 16'hFF60;
    localparam logic [15:0] IDX_CAPCMP_A = 16'hFF62;
    localparam logic [15:0] IDX_CAPCMP_B = 16'hFF64;
    localparam logic [15:0] IDX_MODE = 16'hFF66;
    localparam logic [15:0] IDX_PRESCALE = 16'hFF67;
    localparam logic [15:0] IDX_CAPCTRL = 16'hFF68;
    localparam logic [15:0] IDX_OUTCTRL = 16'hFF69;
    // Reset values and counter maximum
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Mode control fields
    localparam int unsigned MODE_OVF = 0;
    localparam int unsigned MODE_LO = 2;
    // Capture/compare control fields
    localparam int unsigned CC_ROLE_A = 0;
    localparam int unsigned CC_TRIG_A = 1;
    localparam int unsigned CC_ROLE_B = 2;
    // Output control fields
    localparam int unsigned OC_ENABLE = 0;
    localparam int unsigned OC_INV_A = 1;
    localparam int unsigned OC_RESET = 2;
    localparam int unsigned OC_SET = 3;
    localparam int unsigned OC_INV_B = 4;
    // Prescaler and edge select fields
    localparam int unsigned PS_CLK_LO = 0;
    localparam int unsigned PS_EDGE_A_LO = 4;
    localparam int unsigned PS_EDGE_B_LO = 6;
    // Timing: subsystem clock rate and dividers derived from the system clock
    localparam int unsigned CLK_FREQ_HZ = 10_000_000;
    localparam int unsigned SUB_FREQ_HZ = 32_768;
    localparam int unsigned SUB_DIV = CLK_FREQ_HZ / SUB_FREQ_HZ;
    localparam int unsigned HALF_DIV = CLK_FREQ_HZ / (SUB_FREQ_HZ / 2);
    localparam int unsigned X4_DIV = CLK_FREQ_HZ / (SUB_FREQ_HZ * 4);
    localparam int unsigned DIV_W = 10;

    typedef enum logic [1:0]
    {
        TCC_STOP = 2'b00,
        TCC_FREE = 2'b01,
        TCC_CLR_EDGE = 2'b10,
        TCC_CLR_MATCH = 2'b11
    } tcc_mode_type;

    typedef enum logic [1:0]
    {
        TCC_FALL = 2'b00,
        TCC_RISE = 2'b01,
        TCC_BAD = 2'b10,
        TCC_BOTH = 2'b11
    } tcc_edge_sel_type;

    typedef enum logic [1:0]
    {
        TCC_CK_SUB = 2'b00,
        TCC_CK_HALF = 2'b01,
        TCC_CK_X4 = 2'b10,
        TCC_CK_EXT = 2'b11
    } tcc_clk_sel_type;

    typedef struct packed
    {
        logic valid;
        logic inv;
    } tcc_edge_type;
endpackage
`default_nettype wire

// >>> hw/tcc_edge_detect.sv
// Synchroniser and valid-edge detector for one external timer input.
// Assumes the pin is asynchronous to clk; outputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_detect
(
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      pin,
    input  wire tcc_pkg::tcc_edge_sel_type edgeSel,
    output var  tcc_pkg::tcc_edge_type     edges
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;
    logic fall;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    // One pulse per valid edge; inverted edge is absent when both edges count
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            edges <= '0;
        end
        else
        begin
            case (edgeSel)
                tcc_pkg::TCC_FALL: edges <= '{valid: fall, inv: rise};
                tcc_pkg::TCC_RISE: edges <= '{valid: rise, inv: fall};
                tcc_pkg::TCC_BOTH: edges <= '{valid: rise | fall, inv: 1'b0};
                default: edges <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hw/tcc_prescaler.sv
// Count clock selector: turns the system clock into one-cycle count ticks.
// Assumes hold is raised only for short register reads.
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler
(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire tcc_pkg::tcc_clk_sel_type clkSel,
    input  wire logic                     run,
    input  wire logic                     hold,
    input  wire logic                     extEdge,
    output logic                          tick
);
    logic [tcc_pkg::DIV_W-1:0] divCnt_ff;
    logic [tcc_pkg::DIV_W-1:0] limit;
    logic                      pend_ff;
    logic                      divDone;
    logic                      raw;

    always_comb
    begin
        case (clkSel)
            tcc_pkg::TCC_CK_HALF: limit = tcc_pkg::DIV_W'(tcc_pkg::HALF_DIV - 1);
            tcc_pkg::TCC_CK_X4: limit = tcc_pkg::DIV_W'(tcc_pkg::X4_DIV - 1);
            default: limit = tcc_pkg::DIV_W'(tcc_pkg::SUB_DIV - 1);
        endcase
    end

    assign divDone = (divCnt_ff == limit);
    assign raw = (clkSel == tcc_pkg::TCC_CK_EXT) ? extEdge : divDone;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divCnt_ff <= '0;
        end
        else if (!run || divDone)
        begin
            divCnt_ff <= '0;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 1'b1;
        end
    end

    // A tick that falls in a hold is kept and released afterwards
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend_ff <= 1'b0;
        end
        else
        begin
            pend_ff <= run & hold & (raw | pend_ff);
        end
    end

    assign tick = run & ~hold & (raw | pend_ff);
endmodule
`default_nettype wire

// >>> hw/tcc_top.sv
// 16-bit up-counter with two capture/compare registers and a timer output.
// Assumes an APB master on clk; edge inputs are asynchronous pins.
//
// Overview of operation
// - Sixteen-bit read-only counter increments on each selected count clock tick.
// - Reading the counter holds off count ticks, returning a stable snapshot.
// - Counter clears on reset, stop mode, clear-on-edge edge, clear-on-match match.
// - Mode bits 3:2 select stop, free-run, clear-on-edge, clear-on-match.
// - Counting starts when mode is nonzero; software stops it writing zero.
// - Output toggles on matches in free-run and clear-on-match modes only.
// - Clear-on-match with register A at FFFFH sets overflow on wrap.
// - Control bit 0 picks compare or capture for register A.
// - Control bit 2 picks compare or capture for register B.
// - Register A compare match with counter raises interrupt A.
// - Register B compare match with counter raises interrupt B.
// - Control bit 1 picks input B edge or inverted input A edge.
// - Input A edge select sets capture edges for register B and for register A on input A.
// - Register A capture on input B uses input B edge select.
// - Capture of A on input B interrupts; on input A does not.
// - Every capture of register B raises interrupt B.
// - Register A at zero matches on step zero to one after wrap.
// - Register B at zero matches on step zero to one after wrap.
// - Prescaler field picks subsystem clock, half, times four, or input A.
// - Output flop toggles per enabled match; pin low unless output enabled.
// - Reset clears control registers and both capture/compare registers.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tcc_top
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tcc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       edgeInputA,
    input  wire logic                       edgeInputB,
    output logic                            timerOut,
    output logic                            matchIrqA,
    output logic                            matchIrqB
);
    logic [15:0]           upCounter_ff;
    logic [15:0]           capCmpA_ff;
    logic [15:0]           capCmpB_ff;
    logic [7:0]            modeCtrl_ff;
    logic [7:0]            capCtrl_ff;
    logic [7:0]            prescale_ff;
    logic [7:0]            outCtrl_ff;
    logic                  outFlop_ff;
    logic                  armed_ff;
    logic [31:0]           prdata_ff;
    logic                  pslverr_ff;
    logic                  irqA_ff;
    logic                  irqB_ff;
    logic [15:0]           regIdx;
    logic                  aligned;
    logic                  setup;
    logic                  wrAcc;
    logic                  hitCounter;
    logic                  hitCapA;
    logic                  hitCapB;
    logic                  hitMode;
    logic                  hitPrescale;
    logic                  hitCapCtrl;
    logic                  hitOutCtrl;
    logic                  hit;
    logic [31:0]           rdValue;
    tcc_pkg::tcc_mode_type mode;
    logic                  run;
    logic                  hold;
    logic                  tick;
    tcc_pkg::tcc_edge_type edgeA;
    tcc_pkg::tcc_edge_type edgeB;
    logic                  roleA;
    logic                  roleB;
    logic                  trigA;
    logic                  eqA;
    logic                  eqB;
    logic                  matchA;
    logic                  matchB;
    logic                  edgeClear;
    logic                  capA;
    logic                  capB;
    logic                  ovfSet;
    logic                  outToggle;

    // Register decode
    assign regIdx = paddr[tcc_pkg::ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite;
    assign hitCounter = aligned & (regIdx == tcc_pkg::IDX_COUNTER);
    assign hitCapA = aligned & (regIdx == tcc_pkg::IDX_CAPCMP_A);
    assign hitCapB = aligned & (regIdx == tcc_pkg::IDX_CAPCMP_B);
    assign hitMode = aligned & (regIdx == tcc_pkg::IDX_MODE);
    assign hitPrescale = aligned & (regIdx == tcc_pkg::IDX_PRESCALE);
    assign hitCapCtrl = aligned & (regIdx == tcc_pkg::IDX_CAPCTRL);
    assign hitOutCtrl = aligned & (regIdx == tcc_pkg::IDX_OUTCTRL);
    assign hit = hitCounter | hitCapA | hitCapB | hitMode | hitPrescale | hitCapCtrl | hitOutCtrl;

    // Read multiplexer; set/reset strobes of the output control read as zero
    always_comb
    begin
        rdValue = 32'h0000_0000;
        if (hitCounter)
            rdValue[15:0] = upCounter_ff;
        else if (hitCapA)
            rdValue[15:0] = capCmpA_ff;
        else if (hitCapB)
            rdValue[15:0] = capCmpB_ff;
        else if (hitMode)
            rdValue[7:0] = modeCtrl_ff;
        else if (hitPrescale)
            rdValue[7:0] = prescale_ff;
        else if (hitCapCtrl)
            rdValue[7:0] = capCtrl_ff;
        else if (hitOutCtrl)
            rdValue[7:0] = outCtrl_ff;
    end

    // Read data is taken at the setup cycle and stands through the access
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rdValue;
            pslverr_ff <= ~hit;
        end
    end

    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign pready = 1'b1;

    // Count ticks are held off while the counter is being read
    assign hold = psel & ~pwrite & hitCounter;

    // Mode decode
    assign mode = tcc_pkg::tcc_mode_type'(modeCtrl_ff[tcc_pkg::MODE_LO +: 2]);
    assign run = (mode != tcc_pkg::TCC_STOP);
    assign roleA = capCtrl_ff[tcc_pkg::CC_ROLE_A];
    assign trigA = capCtrl_ff[tcc_pkg::CC_TRIG_A];
    assign roleB = capCtrl_ff[tcc_pkg::CC_ROLE_B];

    tcc_edge_detect u_edge_a
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (edgeInputA),
        .edgeSel (tcc_pkg::tcc_edge_sel_type'(prescale_ff[tcc_pkg::PS_EDGE_A_LO +: 2])),
        .edges   (edgeA)
    );

    tcc_edge_detect u_edge_b
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (edgeInputB),
        .edgeSel (tcc_pkg::tcc_edge_sel_type'(prescale_ff[tcc_pkg::PS_EDGE_B_LO +: 2])),
        .edges   (edgeB)
    );

    tcc_prescaler u_prescaler
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkSel  (tcc_pkg::tcc_clk_sel_type'(prescale_ff[tcc_pkg::PS_CLK_LO +: 2])),
        .run     (run),
        .hold    (hold),
        .extEdge (edgeA.valid),
        .tick    (tick)
    );

    // Matches are taken on the tick that leaves the equal count
    assign eqA = (upCounter_ff == capCmpA_ff);
    assign eqB = (upCounter_ff == capCmpB_ff);
    assign matchA = tick & armed_ff & eqA;
    assign matchB = tick & armed_ff & eqB;
    assign edgeClear = (mode == tcc_pkg::TCC_CLR_EDGE) & edgeA.valid;

    // Capture strobes
    assign capA = run & roleA & (trigA ? edgeA.inv : edgeB.valid);
    assign capB = run & roleB & edgeA.valid;

    // Counter
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            upCounter_ff <= tcc_pkg::RST_WORD;
        end
        else if (!run || edgeClear)
        begin
            upCounter_ff <= tcc_pkg::RST_WORD;
        end
        else if (tick)
        begin
            if ((mode == tcc_pkg::TCC_CLR_MATCH) && matchA)
            begin
                upCounter_ff <= tcc_pkg::RST_WORD;
            end
            else
            begin
                upCounter_ff <= upCounter_ff + 16'h0001;
            end
        end
    end

    // A freshly started count does not match on its first tick
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            armed_ff <= 1'b0;
        else if (!run)
            armed_ff <= 1'b0;
        else if (tick)
            armed_ff <= 1'b1;
    end

    // Capture/compare registers; a capture wins over a software write
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            capCmpA_ff <= tcc_pkg::RST_WORD;
        end
        else if (capA)
        begin
            capCmpA_ff <= upCounter_ff;
        end
        else if (wrAcc && hitCapA)
        begin
            capCmpA_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            capCmpB_ff <= tcc_pkg::RST_WORD;
        end
        else if (capB)
        begin
            capCmpB_ff <= upCounter_ff;
        end
        else if (wrAcc && hitCapB)
        begin
            capCmpB_ff <= pwdata[15:0];
        end
    end

    // Overflow on any wrap from FFFFH; in clear-on-match this needs A at FFFFH
    assign ovfSet = tick & ~edgeClear & (upCounter_ff == tcc_pkg::CNT_MAX);

    // Mode control: only the mode field and the overflow flag are stored
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            modeCtrl_ff <= tcc_pkg::RST_BYTE;
        end
        else
        begin
            if (wrAcc && hitMode)
            begin
                modeCtrl_ff[tcc_pkg::MODE_LO +: 2] <= pwdata[tcc_pkg::MODE_LO +: 2];
                modeCtrl_ff[tcc_pkg::MODE_OVF] <= pwdata[tcc_pkg::MODE_OVF] | ovfSet;
            end
            else if (ovfSet)
            begin
                modeCtrl_ff[tcc_pkg::MODE_OVF] <= 1'b1;
            end
        end
    end

    // Capture/compare, prescaler and output control registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            capCtrl_ff <= tcc_pkg::RST_BYTE;
        end
        else if (wrAcc && hitCapCtrl)
        begin
            capCtrl_ff <= {5'b00000, pwdata[2:0]};
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prescale_ff <= tcc_pkg::RST_BYTE;
        end
        else if (wrAcc && hitPrescale)
        begin
            prescale_ff <= {pwdata[7:4], 2'b00, pwdata[1:0]};
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outCtrl_ff <= tcc_pkg::RST_BYTE;
        end
        else if (wrAcc && hitOutCtrl)
        begin
            outCtrl_ff <= {3'b000, pwdata[4], 2'b00, pwdata[1:0]};
        end
    end

    // Output flop: direct set/reset by write, else toggle on enabled matches
    assign outToggle = ((mode == tcc_pkg::TCC_FREE) || (mode == tcc_pkg::TCC_CLR_MATCH))
                       & ((~roleA & matchA & outCtrl_ff[tcc_pkg::OC_INV_A])
                          ^ (~roleB & matchB & outCtrl_ff[tcc_pkg::OC_INV_B]));

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outFlop_ff <= 1'b0;
        end
        else if (wrAcc && hitOutCtrl && pwdata[tcc_pkg::OC_SET])
        begin
            outFlop_ff <= 1'b1;
        end
        else if (wrAcc && hitOutCtrl && pwdata[tcc_pkg::OC_RESET])
        begin
            outFlop_ff <= 1'b0;
        end
        else if (outToggle)
        begin
            outFlop_ff <= ~outFlop_ff;
        end
    end

    assign timerOut = outFlop_ff & outCtrl_ff[tcc_pkg::OC_ENABLE];

    // Interrupt request pulses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqA_ff <= 1'b0;
            irqB_ff <= 1'b0;
        end
        else
        begin
            irqA_ff <= (~roleA & matchA)
                       | (capA & ~trigA);
            irqB_ff <= (~roleB & matchB)
                       | capB;
        end
    end

    assign matchIrqA = irqA_ff;
    assign matchIrqB = irqB_ff;
endmodule
`default_nettype wire

// >>> bench/tcc_top_props.sv
// Port checker of the capture/compare timer.
// Assumes it is bound to tcc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tcc_top_props
(
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       timerOut,
    input wire logic                       matchIrqA,
    input wire logic                       matchIrqB
);
    localparam logic [17:0] A_CNT = {tcc_pkg::IDX_COUNTER, 2'b00};
    localparam logic [17:0] A_MODE = {tcc_pkg::IDX_MODE, 2'b00};
    localparam logic [17:0] A_OUT = {tcc_pkg::IDX_OUTCTRL, 2'b00};
    logic wr;
    logic modeZero_ff;
    assign wr = psel && penable && pwrite;
    // Tracks whether software left the timer in stop mode
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            modeZero_ff <= 1'b1;
        else if (wr && paddr == A_MODE)
            modeZero_ff <= pwdata[3:2] == 2'b00;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rst_quiet; $fell(sys_rst) |-> !matchIrqA && !matchIrqB && !timerOut; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
    property p_irqa_pulse; matchIrqA |=> !matchIrqA; endproperty
    a_irqa_pulse: assert property (p_irqa_pulse) else $error("irq A too long");
    property p_irqb_pulse; matchIrqB |=> !matchIrqB; endproperty
    a_irqb_pulse: assert property (p_irqb_pulse) else $error("irq B too long");
    property p_out_off; wr && paddr == A_OUT && !pwdata[0] |=> !timerOut; endproperty
    a_out_off: assert property (p_out_off) else $error("pin driven while disabled");
    property p_out_set; wr && paddr == A_OUT && pwdata[3:0] == 4'h9 |=> timerOut; endproperty
    a_out_set: assert property (p_out_set) else $error("set strobe lost");
    property p_stop_cnt; psel && !penable && !pwrite && paddr == A_CNT && modeZero_ff |=> prdata == 0; endproperty
    a_stop_cnt: assert property (p_stop_cnt) else $error("counter not clear when stopped");
    property p_stop_quiet; modeZero_ff && $past(modeZero_ff) |-> !matchIrqA && !matchIrqB; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("irq while stopped");
    property p_stop_hold; modeZero_ff && !$past(wr) |-> $stable(timerOut); endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("output moved while stopped");
    property p_hi_zero; psel && !penable && !pwrite |=> prdata[31:16] == 16'h0000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
endmodule
`default_nettype wire

// >>> bench/tcc_pulse_src.sv
// Model of the external pulse sources on the two edge inputs.
// Assumes fire is held for one clock; pins idle low.
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src
#(
    parameter int unsigned WIDTH = 200
)
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] fire,
    output logic            edgeInputA,
    output logic            edgeInputB,
    output logic            busy
);
    int unsigned cnt_ff;
    logic [1:0]  sel_ff;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            cnt_ff <= 0;
        else if (cnt_ff != 0)
            cnt_ff <= cnt_ff - 1;
        else if (fire != 2'b00)
            cnt_ff <= 2 * WIDTH;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            sel_ff <= 2'b00;
        else if (cnt_ff == 0 && fire != 2'b00)
            sel_ff <= fire;
    // Pulse wider than two times-four count clocks so every trigger is seen
    assign edgeInputA = sel_ff[0] && cnt_ff > WIDTH;
    assign edgeInputB = sel_ff[1] && cnt_ff > WIDTH;
    assign busy = cnt_ff != 0;
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the capture/compare timer.
// Assumes the package, design, pulse source and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin errorCnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    localparam logic [17:0] A_CNT = {tcc_pkg::IDX_COUNTER, 2'b00};
    localparam logic [17:0] A_A = {tcc_pkg::IDX_CAPCMP_A, 2'b00};
    localparam logic [17:0] A_B = {tcc_pkg::IDX_CAPCMP_B, 2'b00};
    localparam logic [17:0] A_MODE = {tcc_pkg::IDX_MODE, 2'b00};
    localparam logic [17:0] A_PRE = {tcc_pkg::IDX_PRESCALE, 2'b00};
    localparam logic [17:0] A_CC = {tcc_pkg::IDX_CAPCTRL, 2'b00};
    localparam logic [17:0] A_OUT = {tcc_pkg::IDX_OUTCTRL, 2'b00};
    localparam logic [31:0] ZERO = 32'h0000_0000;
    typedef struct packed {logic w; logic [17:0] a; logic [31:0] d; logic e;} tcc_row_type;
    tcc_row_type rows [13] = '{'{1'b0, A_A, ZERO, 1'b0}, '{1'b0, A_B, ZERO, 1'b0},
        '{1'b0, A_MODE, ZERO, 1'b0}, '{1'b0, A_CC, ZERO, 1'b0}, '{1'b0, A_CNT, ZERO, 1'b0},
        '{1'b1, A_A, 32'h0000_1234, 1'b0}, '{1'b0, A_A, 32'h0000_1234, 1'b0},
        '{1'b1, A_B, 32'hFFFF_ABCD, 1'b0}, '{1'b0, A_B, 32'h0000_ABCD, 1'b0},
        '{1'b1, A_CNT, 32'h0000_0005, 1'b0}, '{1'b0, A_CNT, ZERO, 1'b0},
        '{1'b0, 18'h0_0000, ZERO, 1'b1}, '{1'b0, 18'h3_FD89, ZERO, 1'b1}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0_0000;
    logic [31:0] pwdata = ZERO;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, qErr, edgeInputA, edgeInputB, timerOut, matchIrqA, matchIrqB, busy;
    logic [1:0] fire = 2'b00;
    int errorCnt = 0;
    int totalChecks = 0;
    int irqACnt = 0;
    int irqBCnt = 0;
    always #50 clk = ~clk;
    tcc_top i_tcc_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edgeInputA(edgeInputA), .edgeInputB(edgeInputB), .timerOut(timerOut),
        .matchIrqA(matchIrqA), .matchIrqB(matchIrqB));
    tcc_pulse_src i_tcc_pulse_src (.clk(clk), .sys_rst(sys_rst), .fire(fire),
        .edgeInputA(edgeInputA), .edgeInputB(edgeInputB), .busy(busy));
    always @(posedge clk)
    begin
        if (matchIrqA === 1'b1)
            irqACnt++;
        if (matchIrqB === 1'b1)
            irqBCnt++;
    end
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        qErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [1:0] p);
        @(posedge clk);
        fire <= p;
        @(posedge clk);
        fire <= 2'b00;
        do @(posedge clk); while (busy === 1'b1);
        repeat (8) @(posedge clk);
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        finalReport();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 13; i++)
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            `CHK(qErr, rows[i].e)
            if (!rows[i].w)
                `CHK(q, rows[i].d)
        end
        $display("register table done");
        apb(1'b1, A_A, 32'h0000_0003);
        apb(1'b1, A_PRE, 32'h0000_0013);
        apb(1'b1, A_MODE, 32'h0000_0004);
        irqACnt = 0;
        repeat (5) pulse(2'b01);
        `CHK(irqACnt, 1)
        apb(1'b0, A_CNT, ZERO);
        `CHK(q, 32'h0000_0005)
        `CHK(timerOut, 1'b0)
        apb(1'b1, A_MODE, ZERO);
        apb(1'b0, A_CNT, ZERO);
        `CHK(q, ZERO)
        apb(1'b1, A_MODE, 32'h0000_000C);
        irqACnt = 0;
        repeat (9) pulse(2'b01);
        apb(1'b0, A_CNT, ZERO);
        `CHK(q, 32'h0000_0001)
        `CHK(irqACnt, 2)
        $display("compare test done");
        apb(1'b1, A_MODE, ZERO);
        apb(1'b1, A_PRE, 32'h0000_0052);
        apb(1'b1, A_CC, 32'h0000_0005);
        apb(1'b1, A_MODE, 32'h0000_0004);
        irqACnt = 0;
        irqBCnt = 0;
        pulse(2'b01);
        `CHK(irqBCnt, 1)
        `CHK(irqACnt, 0)
        pulse(2'b10);
        `CHK(irqACnt, 1)
        $display("capture test done");
        apb(1'b1, A_MODE, ZERO);
        apb(1'b1, A_CC, ZERO);
        apb(1'b1, A_MODE, 32'h0000_0008);
        repeat (800) @(posedge clk);
        apb(1'b0, A_CNT, ZERO);
        `CHK(q > 32'h0000_0008, 1'b1)
        pulse(2'b01);
        apb(1'b0, A_CNT, ZERO);
        `CHK(q < 32'h0000_0008, 1'b1)
        apb(1'b1, A_MODE, ZERO);
        $display("clear on edge test done");
        apb(1'b1, A_OUT, 32'h0000_0009);
        @(negedge clk);
        `CHK(timerOut, 1'b1)
        apb(1'b1, A_OUT, 32'h0000_0005);
        @(negedge clk);
        `CHK(timerOut, 1'b0)
        apb(1'b1, A_OUT, 32'h0000_0008);
        @(negedge clk);
        `CHK(timerOut, 1'b0)
        $display("output test done");
        apb(1'b1, A_OUT, 32'h0000_0009);
        apb(1'b1, A_CC, 32'h0000_0005);
        apb(1'b1, A_MODE, 32'h0000_0004);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK(timerOut, 1'b0)
        apb(1'b0, A_MODE, ZERO);
        `CHK(q, ZERO)
        apb(1'b0, A_CC, ZERO);
        `CHK(q, ZERO)
        $display("reset test done");
        finalReport();
    end
endmodule
bind tcc_top tcc_top_props i_tcc_top_props (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .timerOut(timerOut),
    .matchIrqA(matchIrqA), .matchIrqB(matchIrqB));
`default_nettype wire
